// *** sim_cpu_model.sv ***
`timescale 1ns/100ps
// Behavioural stand-in for the CPU core and the board reset pin.
module sim_cpu_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_aux_irq,
   input wire logic i_service_en,
   input wire logic i_slow,
   input wire logic i_reset_pin_o,
   input wire logic i_reset_pin_oe,
   output logic o_service_entry = 1'b0,
   output logic o_pin_level
);
   int wait_cnt; // Latency counter before the service routine is entered.
   // The pin has a weak pull-up, so it reads high unless driven.
   assign o_pin_level = i_reset_pin_oe ? i_reset_pin_o : 1'b1;
   // A slow core takes three extra cycles, which exposes a request that drops early.
   always @(posedge i_clk) begin
      o_service_entry <= 1'b0;
      if (i_rst || !i_service_en || !i_aux_irq || o_service_entry) begin
         wait_cnt <= 0;
      end else if (wait_cnt >= (i_slow ? 3 : 0)) begin
         o_service_entry <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

// *** sim_pkg.sv ***
// Shared constants for the supply integrity monitor.
package sim_pkg;

   // Byte address of the control/status register on the register bus.
   localparam logic [3:0] SIM_CSR_ADDR = 4'h0;

   // Bit positions inside the control/status register.
   localparam int SIM_BIT_IRQ_EN = 0;
   localparam int SIM_BIT_AUX_FLAG = 1;
   localparam int SIM_BIT_LV_RST_FLAG = 2;
   localparam int SIM_BIT_PLL_LOCK = 3;
   localparam int SIM_BIT_WDG_FLAG = 4;

   // Reset values of the stored bits.
   localparam logic SIM_RST_IRQ_EN = 1'b0;
   localparam logic SIM_RST_WDG_FLAG = 1'b0;
   localparam logic SIM_RST_LV_RST_FLAG = 1'b0;
   localparam logic SIM_RST_AUX_FLAG = 1'b0;
   localparam logic SIM_RST_PLL_LOCK = 1'b0;
   localparam logic [1:0] SIM_RST_LEVEL = 2'h0;

   // Threshold level codes driven to the analogue comparator.
   localparam logic [1:0] SIM_LEVEL_LOW = 2'h0;
   localparam logic [1:0] SIM_LEVEL_MEDIUM = 2'h1;
   localparam logic [1:0] SIM_LEVEL_HIGH = 2'h2;

   // AXI4-Lite response codes.
   localparam logic [1:0] SIM_RESP_OKAY = 2'h0;
   localparam logic [1:0] SIM_RESP_SLVERR = 2'h2;

   // Synchroniser depth in flip-flops for the comparator outputs.
   localparam int SIM_SYNC_STAGES = 2;

   // Write channel states of the bus slave.
   typedef enum logic [1:0] {
      SIM_WR_IDLE,
      SIM_WR_HAVE_ADDR,
      SIM_WR_HAVE_DATA,
      SIM_WR_RESP
   } sim_wr_state_t;

endpackage

// *** sim_supply_monitor.sv ***
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps

module sim_supply_monitor
   import sim_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   // Asynchronous outputs of the analogue comparators, high when supply is low.
   input wire logic i_low_voltage_detector_below,
   input wire logic i_aux_supply_detector_below,
   // Nonvolatile option settings.
   input wire logic i_lv_option_enable,
   input wire logic [1:0] i_lv_option_level,
   // Reset cause events and status from neighbouring blocks.
   input wire logic i_watchdog_reset,
   input wire logic i_pll_locked,
   // CPU state.
   input wire logic i_cpu_halt,
   input wire logic i_cpu_wait,
   input wire logic i_cc_irq_mask,
   input wire logic i_irq_service_entry,
   // AXI4-Lite slave.
   input wire logic [3:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [3:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // Supply integrity outputs.
   output logic o_lv_reset,
   output logic o_reset_pin_o,
   output logic o_reset_pin_oe,
   output logic o_lv_threshold_rising,
   output logic [1:0] o_lv_threshold_level,
   output logic o_aux_irq,
   output logic o_wait_wake
);

   // True when a bus address selects the control/status register.
   function automatic logic csr_hit(input logic [3:0] addr);
      csr_hit = (addr == SIM_CSR_ADDR);
   endfunction

   // Synchroniser chains; stage 0 is read only by stage 1.
   logic [SIM_SYNC_STAGES-1:0] lv_sync;
   logic [SIM_SYNC_STAGES-1:0] aux_sync;
   logic [SIM_SYNC_STAGES-1:0] next_lv_sync;
   logic [SIM_SYNC_STAGES-1:0] next_aux_sync;

   // Supply state after synchronisation, gated by the option setting.
   logic lv_active;
   logic aux_below;

   // Stored register bits and the visible copy of the aux flag.
   logic irq_en;
   logic wdg_flag;
   logic lv_rst_flag;
   logic aux_flag;
   logic pll_lock;
   logic [1:0] level;
   logic next_irq_en;
   logic next_wdg_flag;
   logic next_lv_rst_flag;
   logic next_aux_flag;
   logic next_pll_lock;
   logic [1:0] next_level;

   // Interrupt pending latch and the edge memory for the gated aux comparator level.
   logic irq_pending;
   logic aux_prev;
   logic next_irq_pending;
   logic next_aux_prev;

   // Write channel of the bus slave.
   sim_wr_state_t wr_state;
   sim_wr_state_t next_wr_state;
   logic [3:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [1:0] bresp;
   logic [3:0] next_wr_addr;
   logic [31:0] next_wr_data;
   logic [3:0] next_wr_strb;
   logic [1:0] next_bresp;
   logic wr_commit;

   // Read channel of the bus slave.
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic rd_take;
   logic rd_clears_flag;

   // The register image as software sees it; reserved bits read zero.
   logic [7:0] csr_image;

   // Shift the raw comparator levels through two flip-flops each.
   always_comb begin
      next_lv_sync = {lv_sync[0], i_low_voltage_detector_below};
      next_aux_sync = {aux_sync[0], i_aux_supply_detector_below};
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lv_sync <= '0;
         aux_sync <= '0;
      end else begin
         lv_sync <= next_lv_sync;
         aux_sync <= next_aux_sync;
      end
   end

   // Only the final synchroniser stage feeds the block's logic.
   // Without the option the detectors are treated as absent, so a floating
   // comparator cannot reset the chip or raise interrupts.
   always_comb begin
      // With the option off the low-voltage flag simply never sets.
      lv_active = i_lv_option_enable & lv_sync[1];
      aux_below = i_lv_option_enable & aux_sync[1];
   end

   // Reset outputs and the threshold select come from the last synchroniser flip-flop, gated by the option, so the
   // reset request is glitch free; the comparator supplies the hysteresis.
   always_comb begin
      o_lv_reset = lv_active;
      // Open-drain reset pin: low for the whole low-voltage reset.
      o_reset_pin_o = 1'b0;
      o_reset_pin_oe = lv_active;
      // In reset the supply is rising, so the higher threshold applies;
      // while running the lower falling threshold avoids parasitic resets.
      o_lv_threshold_rising = lv_active;
      o_lv_threshold_level = level;
   end

   // Threshold level is taken from the option, with the spare code mapped
   // to the high level so the comparator never sees an undefined setting.
   always_comb begin
      if (i_lv_option_level == SIM_LEVEL_LOW) begin
         next_level = SIM_LEVEL_LOW;
      end else if (i_lv_option_level == SIM_LEVEL_MEDIUM) begin
         next_level = SIM_LEVEL_MEDIUM;
      end else begin
         next_level = SIM_LEVEL_HIGH;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         level <= SIM_RST_LEVEL;
      end else begin
         level <= next_level;
      end
   end

   // A read of the register clears the low-voltage flag when its address is accepted.
   always_comb begin
      rd_take = i_s_axi_arvalid & ~rvalid;
      rd_clears_flag = rd_take & csr_hit(i_s_axi_araddr);
   end

   // Visible register image; bits 7:5 are reserved and read as zero.
   always_comb begin
      csr_image = 8'h00;
      csr_image[SIM_BIT_IRQ_EN] = irq_en;
      csr_image[SIM_BIT_AUX_FLAG] = aux_flag;
      csr_image[SIM_BIT_LV_RST_FLAG] = lv_rst_flag;
      csr_image[SIM_BIT_PLL_LOCK] = pll_lock;
      csr_image[SIM_BIT_WDG_FLAG] = wdg_flag;
   end

   // Next values of the register bits. In Halt every bit holds, which also
   // drops software writes; the detector itself keeps running.
   always_comb begin
      next_irq_en = irq_en;
      next_wdg_flag = wdg_flag;
      next_lv_rst_flag = lv_rst_flag;
      next_aux_flag = aux_flag;
      next_pll_lock = pll_lock;
      if (!i_cpu_halt) begin
         // Aux flag follows the synchronised comparator every cycle.
         next_aux_flag = aux_below;
         next_pll_lock = i_pll_locked;
         // Software may set or clear the enable; a write of zero to the
         // watchdog flag clears it, a one leaves it alone.
         if (wr_commit && wr_strb[0]) begin
            next_irq_en = wr_data[SIM_BIT_IRQ_EN];
            if (!wr_data[SIM_BIT_WDG_FLAG]) begin
               next_wdg_flag = 1'b0;
            end
         end
         // Read side effect clears the low-voltage flag.
         if (rd_clears_flag) begin
            next_lv_rst_flag = 1'b0;
         end
         // Hardware events win over software clears in the same cycle.
         if (i_watchdog_reset) begin
            next_wdg_flag = 1'b1;
         end
         // A low-voltage reset marks its cause and clears the watchdog
         // flag, so the CPU starts with a stable encoding. Later external
         // or watchdog resets never touch this flag.
         if (lv_active) begin
            next_lv_rst_flag = 1'b1;
            next_wdg_flag = 1'b0;
         end
      end
   end

   // Power-on reset leaves the register at zero; the aux flag and PLL lock bits then
   // follow the aux comparator and the PLL input within a few cycles.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_en <= SIM_RST_IRQ_EN;
         wdg_flag <= SIM_RST_WDG_FLAG;
         lv_rst_flag <= SIM_RST_LV_RST_FLAG;
         aux_flag <= SIM_RST_AUX_FLAG;
         pll_lock <= SIM_RST_PLL_LOCK;
      end else begin
         irq_en <= next_irq_en;
         wdg_flag <= next_wdg_flag;
         lv_rst_flag <= next_lv_rst_flag;
         aux_flag <= next_aux_flag;
         pll_lock <= next_pll_lock;
      end
   end

   // Interrupt latch. It is set on the rising edge of the live comparator
   // level, which runs even in Halt, and cleared on service entry. A new
   // event in the clearing cycle wins. Disabling the source drops the
   // pending request, so a stale event never fires after a later enable.
   always_comb begin
      next_aux_prev = aux_below;
      next_irq_pending = irq_pending;
      if (i_irq_service_entry) begin
         next_irq_pending = 1'b0;
      end
      if (!irq_en) begin
         next_irq_pending = 1'b0;
      end
      if (aux_below && !aux_prev && irq_en) begin
         next_irq_pending = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_pending <= 1'b0;
         aux_prev <= 1'b0;
      end else begin
         irq_pending <= next_irq_pending;
         aux_prev <= next_aux_prev;
      end
   end

   // Request to the CPU needs the local enable and a clear global mask.
   // The wake request for Wait ignores the mask and is withheld in Halt.
   always_comb begin
      o_aux_irq = irq_pending & irq_en & ~i_cc_irq_mask;
      o_wait_wake = irq_pending & irq_en & i_cpu_wait & ~i_cpu_halt;
   end

   // Write channel: address and data are taken in either order, then one
   // response. Reserved bits are simply not stored, whatever is written.
   always_comb begin
      next_wr_state = wr_state;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bresp = bresp;
      wr_commit = 1'b0;
      o_s_axi_awready = 1'b0;
      o_s_axi_wready = 1'b0;
      case (wr_state)
         SIM_WR_IDLE: begin
            o_s_axi_awready = 1'b1;
            o_s_axi_wready = 1'b1;
            if (i_s_axi_awvalid) begin
               next_wr_addr = i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid) begin
               next_wr_data = i_s_axi_wdata;
               next_wr_strb = i_s_axi_wstrb;
            end
            if (i_s_axi_awvalid && i_s_axi_wvalid) begin
               next_wr_state = SIM_WR_RESP;
            end else if (i_s_axi_awvalid) begin
               next_wr_state = SIM_WR_HAVE_ADDR;
            end else if (i_s_axi_wvalid) begin
               next_wr_state = SIM_WR_HAVE_DATA;
            end
         end
         SIM_WR_HAVE_ADDR: begin
            o_s_axi_wready = 1'b1;
            if (i_s_axi_wvalid) begin
               next_wr_data = i_s_axi_wdata;
               next_wr_strb = i_s_axi_wstrb;
               next_wr_state = SIM_WR_RESP;
            end
         end
         SIM_WR_HAVE_DATA: begin
            o_s_axi_awready = 1'b1;
            if (i_s_axi_awvalid) begin
               next_wr_addr = i_s_axi_awaddr;
               next_wr_state = SIM_WR_RESP;
            end
         end
         SIM_WR_RESP: begin
            // Commit on the cycle the response is accepted.
            if (i_s_axi_bready) begin
               wr_commit = csr_hit(wr_addr);
               next_wr_state = SIM_WR_IDLE;
            end
         end
         default: begin
            next_wr_state = SIM_WR_IDLE;
         end
      endcase
      // Response code is settled on entry to the response state.
      if (next_wr_state == SIM_WR_RESP && wr_state != SIM_WR_RESP) begin
         next_bresp = csr_hit(next_wr_addr) ? SIM_RESP_OKAY : SIM_RESP_SLVERR;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_state <= SIM_WR_IDLE;
         wr_addr <= 4'h0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         bresp <= SIM_RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         bresp <= next_bresp;
      end
   end

   always_comb begin
      o_s_axi_bvalid = (wr_state == SIM_WR_RESP);
      o_s_axi_bresp = bresp;
   end

   // Read channel: one cycle from address to data. Unmapped addresses read
   // zero with an error response. The returned value is the image before
   // the read-clear takes effect, so software sees the set flag once.
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && i_s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (rd_take) begin
         next_rvalid = 1'b1;
         if (csr_hit(i_s_axi_araddr)) begin
            next_rdata = {24'h00_0000, csr_image};
            next_rresp = SIM_RESP_OKAY;
         end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = SIM_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= SIM_RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   always_comb begin
      o_s_axi_arready = ~rvalid;
      o_s_axi_rvalid = rvalid;
      o_s_axi_rdata = rdata;
      o_s_axi_rresp = rresp;
   end

endmodule

// *** sim_supply_monitor_assertions.sv ***
`timescale 1ns/100ps
// Watches the port behaviour of the supply integrity monitor.
module sim_supply_monitor_assertions
   import sim_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_low_voltage_detector_below,
   input wire logic i_aux_supply_detector_below,
   input wire logic i_lv_option_enable,
   input wire logic [1:0] i_lv_option_level,
   input wire logic i_cc_irq_mask,
   input wire logic i_irq_service_entry,
   input wire logic i_cpu_halt,
   input wire logic i_cpu_wait,
   input wire logic o_s_axi_rvalid,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_lv_reset,
   input wire logic o_reset_pin_o,
   input wire logic o_reset_pin_oe,
   input wire logic o_lv_threshold_rising,
   input wire logic [1:0] o_lv_threshold_level,
   input wire logic o_aux_irq,
   input wire logic o_wait_wake
);
   // Everything runs on one clock, so one clocking and one disable do.
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Four samples cover the two synchroniser stages; the outputs are not registered.
   a_lv_low_supply: assert property (
      (i_low_voltage_detector_below && i_lv_option_enable)[*4] |-> o_lv_reset)
      else $error("lv reset missing");
   a_lv_good_supply: assert property (
      (!i_low_voltage_detector_below)[*4] |-> !o_lv_reset)
      else $error("lv reset on good supply");
   a_lv_opt_off: assert property (
      (!i_lv_option_enable)[*3] |-> !o_lv_reset)
      else $error("lv reset with option off");
   a_pin_follow_lv: assert property (
      o_reset_pin_oe == o_lv_reset && !o_reset_pin_o)
      else $error("reset pin wrong");
   a_thr_rising: assert property (
      o_lv_threshold_rising == o_lv_reset)
      else $error("threshold select wrong");
   a_thr_level: assert property (
      !$past(i_rst) && $past(i_lv_option_level) != 2'h3
      |-> o_lv_threshold_level == $past(i_lv_option_level)) else $error("level wrong");
   a_irq_masked: assert property (
      o_aux_irq |-> !i_cc_irq_mask)
      else $error("irq while masked");
   // A steady comparator level cannot make a new edge, so service must win.
   a_irq_service: assert property (
      $stable(i_aux_supply_detector_below)[*4] ##0 i_irq_service_entry |=> !o_aux_irq)
      else $error("irq kept after service");
   a_wake_wait: assert property (
      o_wait_wake |-> i_cpu_wait && !i_cpu_halt)
      else $error("wake outside wait");
   a_rd_reserved: assert property (
      o_s_axi_rvalid |-> o_s_axi_rdata[31:5] == 27'h0)
      else $error("reserved bits set");
   c_lv: cover property (o_lv_reset ##1 !o_lv_reset);
   c_irq: cover property (o_aux_irq ##1 !o_aux_irq);
   c_wake: cover property (o_wait_wake);
endmodule

bind sim_supply_monitor sim_supply_monitor_assertions i_chk (.i_clk, .i_rst,
   .i_low_voltage_detector_below, .i_aux_supply_detector_below, .i_lv_option_enable,
   .i_lv_option_level, .i_cc_irq_mask, .i_irq_service_entry, .i_cpu_halt, .i_cpu_wait,
   .o_s_axi_rvalid, .o_s_axi_rdata, .o_lv_reset, .o_reset_pin_o, .o_reset_pin_oe,
   .o_lv_threshold_rising, .o_lv_threshold_level, .o_aux_irq, .o_wait_wake);

// *** tb_top.sv ***
`timescale 1ns/100ps
// Self-checking bench for the supply integrity monitor.
module tb_top
   import sim_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic lv_below = 1'b0, aux_below = 1'b0, opt_en = 1'b1, wdg = 1'b0, pll = 1'b0;
   logic halt = 1'b0, cwait = 1'b0, mask = 1'b0, svc_en = 1'b0, slow = 1'b0;
   logic [1:0] opt_lvl = 2'h2;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rnd;
   logic aw_rdy, w_rdy, ar_rdy, bvalid, rvalid, lv_rst, pin_o, pin_oe, thr_rise;
   logic aux_irq, wake, svc, pin_lvl;
   logic [1:0] bresp, rresp, thr_lvl;
   logic [33:0] rd_q[$]; // Expected read response and data, oldest first.
   logic [1:0] wr_q[$]; // Expected write responses.
   int n_errors = 0;
   int cmp_count = 0;
   int n;
   int k;
   always #12.5 i_clk = ~i_clk;
   sim_supply_monitor i_dut (.i_clk, .i_rst, .i_low_voltage_detector_below(lv_below),
      .i_aux_supply_detector_below(aux_below), .i_lv_option_enable(opt_en),
      .i_lv_option_level(opt_lvl), .i_watchdog_reset(wdg), .i_pll_locked(pll),
      .i_cpu_halt(halt), .i_cpu_wait(cwait), .i_cc_irq_mask(mask), .i_irq_service_entry(svc),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(aw_rdy),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(w_rdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(1'b1), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(ar_rdy), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1), .o_lv_reset(lv_rst),
      .o_reset_pin_o(pin_o), .o_reset_pin_oe(pin_oe), .o_lv_threshold_rising(thr_rise),
      .o_lv_threshold_level(thr_lvl), .o_aux_irq(aux_irq), .o_wait_wake(wake));
   sim_cpu_model i_cpu (.i_clk, .i_rst, .i_aux_irq(aux_irq), .i_service_en(svc_en),
      .i_slow(slow), .i_reset_pin_o(pin_o), .i_reset_pin_oe(pin_oe),
      .o_service_entry(svc), .o_pin_level(pin_lvl));
   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic sig(input string nm, input logic e, input logic g);
      chk(nm, {33'h0, e}, {33'h0, g});
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge i_clk);
   endtask
   // Bounds every wait; an overrun counts as a mismatch and ends the run.
   task automatic guard(inout int c);
      c++;
      if (c > 64) begin
         n_errors++;
         $display("[FAIL] wait expected done seen timeout");
         complete_run();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
      int c;
      logic aw;
      logic w;
      logic [31:0] fill; // Local draw, so the caller's random value survives.
      c = 0;
      aw = 1'b0;
      w = 1'b0;
      fill = $urandom();
      wr_q.push_back(r);
      awaddr <= a;
      wdata <= {fill[31:8], d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge i_clk);
         if (!aw && aw_rdy) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && w_rdy) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
         guard(c);
      end
      do begin @(posedge i_clk); guard(c); end while (!bvalid);
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
      int c;
      c = 0;
      rd_q.push_back({r, 24'h0, d});
      araddr <= a;
      arvalid <= 1'b1;
      do begin @(posedge i_clk); guard(c); end while (!ar_rdy);
      arvalid <= 1'b0;
      do begin @(posedge i_clk); guard(c); end while (!rvalid);
   endtask
   task automatic wdg_pulse();
      wdg <= 1'b1;
      @(posedge i_clk);
      wdg <= 1'b0;
      tick(2);
   endtask
   task automatic lv_cycle();
      lv_below <= 1'b1;
      tick(6);
      sig("lv_reset", 1'b1, lv_rst);
      sig("pin", 1'b0, pin_lvl);
      sig("thr_rise", 1'b1, thr_rise);
      lv_below <= 1'b0;
      tick(6);
      sig("pin", 1'b1, pin_lvl);
      sig("thr_rise", 1'b0, thr_rise);
   endtask
   // Responses are taken off the queues as they appear; ready is always high.
   always @(posedge i_clk) begin
      if (rvalid) begin
         chk("read", rd_q.size() ? rd_q.pop_front() : 34'h3FFFFFFFF, {rresp, rdata});
      end
      if (bvalid) begin
         chk("bresp", {32'h0, wr_q.size() ? wr_q.pop_front() : 2'h3}, {32'h0, bresp});
      end
   end
   initial begin
      void'($urandom(77835));
      tick(4);
      i_rst <= 1'b0;
      tick(4);
      rd(SIM_CSR_ADDR, 8'h00, SIM_RESP_OKAY);
      rd(4'h4, 8'h00, SIM_RESP_SLVERR);
      pll <= 1'b1;
      tick(2);
      rd(SIM_CSR_ADDR, 8'h08, SIM_RESP_OKAY);
      wr(SIM_CSR_ADDR, 8'h01, SIM_RESP_OKAY);
      wr(4'h8, 8'h00, SIM_RESP_SLVERR);
      wdg_pulse();
      rd(SIM_CSR_ADDR, 8'h19, SIM_RESP_OKAY);
      wr(SIM_CSR_ADDR, 8'h11, SIM_RESP_OKAY);
      rd(SIM_CSR_ADDR, 8'h19, SIM_RESP_OKAY);
      wr(SIM_CSR_ADDR, 8'h01, SIM_RESP_OKAY);
      rd(SIM_CSR_ADDR, 8'h09, SIM_RESP_OKAY);
      aux_below <= 1'b1;
      tick(6);
      sig("aux_irq", 1'b1, aux_irq);
      rd(SIM_CSR_ADDR, 8'h0B, SIM_RESP_OKAY);
      mask <= 1'b1;
      cwait <= 1'b1;
      tick(1);
      sig("aux_irq", 1'b0, aux_irq);
      sig("wake", 1'b1, wake);
      halt <= 1'b1;
      tick(1);
      sig("wake", 1'b0, wake);
      wr(SIM_CSR_ADDR, 8'h00, SIM_RESP_OKAY);
      rd(SIM_CSR_ADDR, 8'h0B, SIM_RESP_OKAY);
      halt <= 1'b0;
      cwait <= 1'b0;
      mask <= 1'b0;
      rnd = $urandom();
      slow <= rnd[0];
      svc_en <= 1'b1;
      n = 0;
      do begin @(posedge i_clk); guard(n); end while (aux_irq);
      tick(3);
      sig("aux_irq", 1'b0, aux_irq);
      svc_en <= 1'b0;
      aux_below <= 1'b0;
      wr(SIM_CSR_ADDR, 8'h00, SIM_RESP_OKAY);
      aux_below <= 1'b1;
      tick(6);
      sig("aux_irq", 1'b0, aux_irq);
      rd(SIM_CSR_ADDR, 8'h0A, SIM_RESP_OKAY);
      aux_below <= 1'b0;
      for (k = 0; k < 2; k++) begin
         wdg_pulse();
         lv_cycle();
         if (k == 1) begin
            wdg_pulse();
         end
         rd(SIM_CSR_ADDR, k ? 8'h1C : 8'h0C, SIM_RESP_OKAY);
         rd(SIM_CSR_ADDR, k ? 8'h18 : 8'h08, SIM_RESP_OKAY);
      end
      opt_en <= 1'b0;
      wr(SIM_CSR_ADDR, 8'h01, SIM_RESP_OKAY);
      lv_below <= 1'b1;
      aux_below <= 1'b1;
      tick(6);
      sig("lv_reset", 1'b0, lv_rst);
      sig("aux_irq", 1'b0, aux_irq);
      lv_below <= 1'b0;
      aux_below <= 1'b0;
      // Let both synchronisers drain first; re-enabling the option on stale
      // low-supply samples would set the low-voltage flag.
      tick(3);
      opt_en <= 1'b1;
      // The spare code 3 must select the high threshold.
      for (k = 0; k < 4; k++) begin
         opt_lvl <= k[1:0];
         tick(2);
         chk("level", {32'h0, ((k == 3) ? SIM_LEVEL_HIGH : k[1:0])}, {32'h0, thr_lvl});
      end
      // Random enables; reserved bits 7:5 are written as zero, bits 31:8 carry random fill.
      for (k = 0; k < 4; k++) begin
         rnd = $urandom();
         wr(SIM_CSR_ADDR, rnd[7:0] & 8'h1F, SIM_RESP_OKAY);
         rd(SIM_CSR_ADDR, {7'h04, rnd[0]}, SIM_RESP_OKAY);
      end
      tick(2);
      complete_run();
   end
endmodule
